//--- verilog/cell_bus_port.sv
/*
  byte-wide cell port. rx side sends stored cells out, tx side takes cells in.
  assumes both link clocks are slower than sys_clk/4; each is synchronised and
  its rising edge is the transfer edge. rx cells sit in a one-cell buffer; tx bytes go straight to the user side.
*/
`timescale 1ns/1ps
module cell_bus_port
  import cell_port_pkg::*;
#(
  parameter logic [4:0] MY_ADDR = PORT_ADDR_RST
) (
  // system
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        master_mode,
  // user side: cell to send toward partner
  input  wire logic [7:0]  user_rx_byte,
  input  wire logic        user_rx_valid,
  output logic             user_rx_ready,
  // user side: cell received from partner
  output logic [7:0]       user_tx_byte,
  output logic             user_tx_first,
  output logic             user_tx_valid,
  output logic             user_tx_parity_err,
  // receive link
  input  wire logic        rx_transfer_clock,
  input  wire logic [4:0]  rx_port_select,
  output logic [7:0]       rx_cell_byte,
  output logic             rx_odd_parity_bit,
  output logic             rx_cell_start_flag,
  input  wire logic        rx_cell_available_in,
  output logic             rx_cell_available_out,
  output logic             rx_cell_available_oe_n,
  input  wire logic        rx_transfer_enable_n_in,
  output logic             rx_transfer_enable_n_out,
  output logic             rx_transfer_enable_n_oe_n,
  // transmit link
  input  wire logic        tx_transfer_clock,
  input  wire logic [4:0]  tx_port_select,
  input  wire logic [7:0]  tx_cell_byte,
  input  wire logic        tx_odd_parity_bit,
  input  wire logic        tx_cell_start_flag,
  input  wire logic        tx_transfer_enable_n,
  output logic             tx_cell_space_available,
  output logic             tx_cell_space_oe_n
);

  function automatic logic odd_par(input logic [7:0] d);
    odd_par = ~(^d);
  endfunction

  // two-stage synchronisers; edge found on the second and third stages
  logic [2:0] rclk_ff, tclk_ff;
  logic [1:0] ren_ff, rclav_ff;
  logic [4:0] radr_s1_ff, radr_ff, tadr_s1_ff, tadr_ff;
  logic [10:0] td_s1_ff, td_ff;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rclk_ff    <= '0;
      tclk_ff    <= '0;
      ren_ff     <= 2'b11;
      rclav_ff   <= '0;
      radr_s1_ff <= '0;
      radr_ff    <= '0;
      tadr_s1_ff <= '0;
      tadr_ff    <= '0;
      td_s1_ff   <= 11'h001;
      td_ff      <= 11'h001;
    end else begin
      rclk_ff    <= {rclk_ff[1:0], rx_transfer_clock};
      tclk_ff    <= {tclk_ff[1:0], tx_transfer_clock};
      ren_ff     <= {ren_ff[0], rx_transfer_enable_n_in};
      rclav_ff   <= {rclav_ff[0], rx_cell_available_in};
      radr_s1_ff <= rx_port_select;
      radr_ff    <= radr_s1_ff;
      tadr_s1_ff <= tx_port_select;
      tadr_ff    <= tadr_s1_ff;
      td_s1_ff   <= {tx_cell_byte, tx_odd_parity_bit, tx_cell_start_flag, tx_transfer_enable_n};
      td_ff      <= td_s1_ff;
    end
  end
  logic rx_edge, tx_edge;
  assign rx_edge = rclk_ff[1] & ~rclk_ff[2];
  assign tx_edge = tclk_ff[1] & ~tclk_ff[2];

  // ---------------- receive direction: buffer and send ----------------
  logic [7:0] rbuf [0:CELL_BYTES-1];
  logic [5:0] wr_idx_ff, rd_idx_ff;
  logic       full_ff, active_ff, sel_ff, ren_drv_ff;
  logic       take;
  assign user_rx_ready = ~full_ff;
  assign take = user_rx_valid & ~full_ff;

  always_ff @(posedge sys_clk) begin
    if (take)
      rbuf[wr_idx_ff] <= user_rx_byte;
  end

  // rx_transfer_enable_n low at edge k: byte shown after edge k, sampled at k+1
  logic go;
  assign go = rx_edge & sel_ff & full_ff &
              (master_mode ? (~ren_drv_ff & rclav_ff[1]) : ~ren_ff[1]);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_idx_ff  <= '0;
      rd_idx_ff  <= '0;
      full_ff    <= 1'b0;
      active_ff  <= 1'b0;
      sel_ff     <= 1'b0;
      ren_drv_ff <= 1'b1;
      rx_cell_byte       <= '0;
      rx_odd_parity_bit  <= 1'b1;
      rx_cell_start_flag <= 1'b0;
    end else begin
      if (take) begin
        wr_idx_ff <= (wr_idx_ff == LAST_INDEX) ? 6'h00 : wr_idx_ff + 6'h01;
        if (wr_idx_ff == LAST_INDEX)
          full_ff <= 1'b1;
      end
      if (rx_edge) begin
        sel_ff     <= (radr_ff == MY_ADDR) | active_ff;
        ren_drv_ff <= ~(master_mode & full_ff & rclav_ff[1]);
      end
      if (go) begin
        rx_cell_byte       <= rbuf[rd_idx_ff];
        rx_odd_parity_bit  <= odd_par(rbuf[rd_idx_ff]);
        rx_cell_start_flag <= (rd_idx_ff == 6'h00);
        active_ff          <= (rd_idx_ff != LAST_INDEX);
        rd_idx_ff          <= (rd_idx_ff == LAST_INDEX) ? 6'h00 : rd_idx_ff + 6'h01;
        if (rd_idx_ff == LAST_INDEX)
          full_ff <= 1'b0;
      end else if (rx_edge) begin
        rx_cell_start_flag <= 1'b0;
      end
    end
  end

  assign rx_cell_available_out     = full_ff;
  assign rx_cell_available_oe_n    = master_mode | ~(radr_ff == MY_ADDR);
  assign rx_transfer_enable_n_out  = ren_drv_ff;
  assign rx_transfer_enable_n_oe_n = ~master_mode;

  // ---------------- transmit direction: receive cells ----------------
  logic [5:0] t_idx_ff;
  logic       t_in_cell_ff;
  logic       t_sel_ff;
  logic       t_fire;
  assign t_fire = tx_edge & ~td_ff[0] & t_sel_ff;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      t_idx_ff           <= '0;
      t_in_cell_ff       <= 1'b0;
      t_sel_ff           <= 1'b0;
      user_tx_byte       <= '0;
      user_tx_first      <= 1'b0;
      user_tx_valid      <= 1'b0;
      user_tx_parity_err <= 1'b0;
    end else begin
      user_tx_valid <= 1'b0;
      if (tx_edge)
        t_sel_ff <= (tadr_ff == MY_ADDR) | t_in_cell_ff;
      if (t_fire) begin
        if (td_ff[1] | t_in_cell_ff) begin
          user_tx_byte       <= td_ff[10:3];
          user_tx_first      <= td_ff[1];
          user_tx_valid      <= 1'b1;
          user_tx_parity_err <= (td_ff[2] != odd_par(td_ff[10:3]));
          t_idx_ff           <= td_ff[1] ? 6'h01 : t_idx_ff + 6'h01;
          t_in_cell_ff       <= td_ff[1] | (t_idx_ff != LAST_INDEX);
        end
      end
    end
  end
  assign tx_cell_space_available = 1'b1;
  assign tx_cell_space_oe_n      = master_mode | ~(tadr_ff == MY_ADDR);


  // named steps of a transfer, shared by the checks below
  sequence s_rx_send;
    go;
  endsequence

  sequence s_rx_last;
    go && (rd_idx_ff == LAST_INDEX);
  endsequence

  sequence s_rx_idle;
    !go;
  endsequence

  sequence s_tx_accept;
    t_fire && (td_ff[1] | t_in_cell_ff);
  endsequence

  a_rx_soc_first: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_rx_send |=> (rx_cell_start_flag == ($past(rd_idx_ff) == 6'h00)))
    else $error("start flag wrong");

  a_rx_parity_odd: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(rx_edge) |-> ^{rx_cell_byte, rx_odd_parity_bit})
    else $error("parity not odd");

  a_rx_clav_full: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    rx_cell_available_out == full_ff)
    else $error("cell available mismatch");

  a_mode_dir: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    master_mode |-> (rx_cell_available_oe_n && !rx_transfer_enable_n_oe_n))
    else $error("direction wrong");

  // the byte on the link must not move between transfers
  a_rx_byte_hold: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_rx_idle |=> ($stable(rx_cell_byte) && $stable(rx_odd_parity_bit)))
    else $error("rx byte moved without transfer");

  a_rx_cell_end: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_rx_last |=> (!full_ff && (rd_idx_ff == 6'h00)))
    else $error("cell did not end after last byte");

  a_tx_accept_pulse: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_tx_accept |=> (user_tx_valid && (user_tx_first == $past(td_ff[1]))))
    else $error("accepted tx byte not handed on");
endmodule

//--- verilog/cell_port_pkg.sv
/*
  constants shared by the cell bus port: cell length, bus widths, port address.
  assumes a single system clock; link clocks are sampled as plain inputs.
*/
// Functional notes
// - receive byte out, bit 7 most significant
// - receive parity makes nine bits odd
// - start flag high only on first byte
// - slave: cell available high when cell held
// - slave: enable low, byte valid next cycle
// - master: device drives enable, samples next cycle
// - slave: space available when able to accept
package cell_port_pkg;
  localparam int unsigned CELL_BYTES    = 53;
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned ADDR_W        = 5;
  localparam logic [5:0]  LAST_INDEX    = 6'h34;
  localparam logic [4:0]  PORT_ADDR_RST = 5'h00;
endpackage

//--- testbench/atm_side_model.sv
/* atm-layer partner: makes both link clocks only while one of its tasks runs, some edges with enable high.
   assumes the port is a slave. */
`timescale 1ns/1ps
module atm_side_model (
  // receive link
  output logic       rx_transfer_clock,
  output logic       rx_transfer_enable_n,
  // transmit link
  output logic       tx_transfer_clock,
  output logic [7:0] tx_cell_byte,
  output logic       tx_odd_parity_bit,
  output logic       tx_cell_start_flag,
  output logic       tx_transfer_enable_n
);
  initial begin
    {rx_transfer_clock, tx_transfer_clock} = 2'b00;
    {rx_transfer_enable_n, tx_transfer_enable_n} = 2'b11;
    {tx_cell_byte, tx_odd_parity_bit, tx_cell_start_flag} = 10'h3fe;
  end
  // enable low on 53 edges, each byte taken one edge later
  task pull_cell();
    for (int i = 0; i < 56; i++) begin
      #32 rx_transfer_clock = 1'b1;
      #32 rx_transfer_clock = 1'b0;
      rx_transfer_enable_n = !(i < 53);
    end
  endtask
  task push_byte(input logic [7:0] b, input logic soc, input logic par);
    tx_cell_byte = b;
    tx_odd_parity_bit = par;
    tx_cell_start_flag = soc;
    tx_transfer_enable_n = 1'b0;
    #32 tx_transfer_clock = 1'b1;
    #32 tx_transfer_clock = 1'b0;
  endtask
  // one clock with enable high so the addressed port latches its selection
  task tx_select();
    tx_transfer_enable_n = 1'b1;
    #32 tx_transfer_clock = 1'b1;
    #32 tx_transfer_clock = 1'b0;
  endtask
  // released bus shows the inverse, not the last byte
  task tx_idle();
    tx_transfer_enable_n = 1'b1;
    tx_cell_byte = ~tx_cell_byte;
  endtask
endmodule

//--- testbench/cell_bus_port_tb.sv
/* bench for cell_bus_port: rx cell out through the partner, two tx cells in.
   runs slave mode at port address 0, then checks the master-mode directions. */
`timescale 1ns/1ps
module cell_bus_port_tb;
  import cell_port_pkg::*;
  logic sys_clk, reset_n, user_rx_valid, rx_par, tx_par, rx_soc, tx_soc, rx_en_n, tx_en_n, rx_lck, tx_lck;
  logic valid, first, perr, clav, clav_oe_n, p, en_q;
  logic rdy, space, space_oe_n, ren_out, ren_oe_n, mode, rclav_in;
  logic [7:0] user_rx_byte, rx_byte, tx_byte, user_tx_byte, b;
  logic [4:0] rx_sel;
  logic [9:0] rxq[$], txq[$];
  int error_cnt, checks, seed;
  cell_bus_port DUT (.sys_clk(sys_clk), .reset_n(reset_n), .master_mode(mode), .user_rx_byte(user_rx_byte),
    .user_rx_valid(user_rx_valid), .user_rx_ready(rdy), .user_tx_byte(user_tx_byte), .user_tx_first(first),
    .user_tx_valid(valid), .user_tx_parity_err(perr), .rx_transfer_clock(rx_lck), .rx_port_select(rx_sel),
    .rx_cell_byte(rx_byte), .rx_odd_parity_bit(rx_par), .rx_cell_start_flag(rx_soc),
    .rx_cell_available_in(rclav_in), .rx_cell_available_out(clav), .rx_cell_available_oe_n(clav_oe_n),
    .rx_transfer_enable_n_in(rx_en_n), .rx_transfer_enable_n_out(ren_out), .rx_transfer_enable_n_oe_n(ren_oe_n),
    .tx_transfer_clock(tx_lck), .tx_port_select(5'h00), .tx_cell_byte(tx_byte), .tx_odd_parity_bit(tx_par),
    .tx_cell_start_flag(tx_soc), .tx_transfer_enable_n(tx_en_n), .tx_cell_space_available(space),
    .tx_cell_space_oe_n(space_oe_n));
  atm_side_model m (.rx_transfer_clock(rx_lck), .rx_transfer_enable_n(rx_en_n), .tx_transfer_clock(tx_lck),
    .tx_cell_byte(tx_byte), .tx_odd_parity_bit(tx_par), .tx_cell_start_flag(tx_soc),
    .tx_transfer_enable_n(tx_en_n));
  task chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #50000 error_cnt++;
    wrap_up();
  end
  // rx byte is sampled one link edge after enable was seen low
  always @(posedge rx_lck) begin
    if (en_q === 1'b0) chk({rx_soc, rx_par, rx_byte}, rxq.pop_front());
    en_q = rx_en_n;
  end
  always @(negedge sys_clk) if (valid === 1'b1) chk({user_tx_byte, first, perr}, txq.pop_front());
  initial begin
    seed = 32'ha56d;
    {reset_n, user_rx_valid, user_rx_byte, en_q} = 11'h001;
    rx_sel = 5'h1f;
    mode = 1'b0;
    rclav_in = 1'b0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk) reset_n = 1'b1;
    for (int i = 0; i < 53; i++) begin
      @(negedge sys_clk);
      b = $random(seed);
      user_rx_byte = b;
      user_rx_valid = 1'b1;
      rxq.push_back({i == 0, ~^b, b});
    end
    @(negedge sys_clk) user_rx_valid = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk({rdy, clav_oe_n}, 2'b01);
    rx_sel = 5'h00;
    repeat (8) @(negedge sys_clk);
    chk({clav_oe_n, clav}, 2'b01);
    chk({ren_oe_n, space, space_oe_n}, 3'b110);
    m.pull_cell();
    repeat (8) @(negedge sys_clk);
    chk(10'(rxq.size()), 10'h000);
    chk({rdy, clav}, 2'b10);
    $display("rx cell test done");
    m.tx_select();
    for (int c = 0; c < 2; c++) for (int i = 0; i < 53; i++) begin
      b = $random(seed);
      p = c == 1 && i == 5;
      txq.push_back({b, i == 0, p});
      m.push_byte(b, i == 0, ~^b ^ p);
    end
    m.tx_idle();
    repeat (20) @(negedge sys_clk);
    chk(10'(txq.size()), 10'h000);
    $display("tx cell test done");
    mode = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk({clav_oe_n, ren_oe_n, ren_out, space_oe_n}, 4'b1011);
    $display("master direction test done");
    wrap_up();
  end
endmodule
